/* File: utic_params.svh */
// constants of the usb/timer interrupt controller
`ifndef UTIC_PARAMS_SVH
`define UTIC_PARAMS_SVH

`define UTIC_IDX_INTC 8'h0b
`define UTIC_IDX_USBREQ 8'h21
`define UTIC_IDX_USBSC 8'h20
`define UTIC_IDX_CORE 8'h40
`define UTIC_BIT_GIE 0
`define UTIC_BIT_UIE 1
`define UTIC_BIT_AIE 2
`define UTIC_BIT_BIE 3
`define UTIC_BIT_UPEND 4
`define UTIC_BIT_APEND 5
`define UTIC_BIT_BPEND 6
`define UTIC_BIT_SUSP 0
`define UTIC_BIT_RESM 3
`define UTIC_INTC_RESET 7'h00
`define UTIC_INTC_MASK 8'h7f
`define UTIC_VEC_USB 12'h004
`define UTIC_VEC_TA 12'h008
`define UTIC_VEC_TB 12'h00c
`define UTIC_RESP_OKAY 2'b00
`define UTIC_RESP_SLVERR 2'b10
`define UTIC_FIFO_N 3

`endif

/* File: utic_pkg.sv */
// types of the usb/timer interrupt controller
package utic_pkg;

    typedef struct packed {
        logic fifo_hit_0;
        logic fifo_hit_1;
        logic fifo_hit_2;
        logic suspend;
        logic resume;
        logic bus_reset;
    } utic_usb_ev_t;

    typedef struct packed {
        logic irq_exit;
        logic sub_exit;
        logic halt_enter;
        logic stack_full;
    } utic_core_t;

    typedef struct packed {
        logic take;
        logic [11:0] vector;
        logic push_pc;
    } utic_ack_t;

endpackage : utic_pkg

/* File: utic_top.sv */
// interrupt controller for usb engine and two timers, axi4-lite registers
`timescale 1ns/100ps
`include "utic_params.svh"

// Summary of operation
// - fifo access, suspend, resume or bus reset sets the usb pending flag
// - enabled usb request with free stack vectors to 04h
// - taking usb clears its pending flag and the global enable
// - timer a overflow sets pending flag bit 5
// - enabled timer a vectors to 08h, clearing its flag and global enable
// - timer b overflow sets pending flag bit 6
// - enabled timer b vectors to 0ch, clearing its flag and global enable
// - no acknowledge while the stack is full
// - flags still record requests while service is blocked
// - software re-enabling global and source enable allows nesting
// - taking an interrupt pushes only the program counter
// - acknowledges held until irq exit or enables set again
// - irq exit sets the global enable, plain return does not
// - requests between phase-two pulses are served on the next pulse
// - fixed priority: usb, then timer a, then timer b
// - clearing the global enable masks all three sources
// - every source can wake the halted device
// - fifo access sets its request bit and the usb flag; firmware clears
// - suspend sets status bit 0 and raises the usb interrupt
// - resume sets status bit 3 and raises the usb interrupt
// - enables: global bit 0, usb 1, timer a 2, timer b 3
// - flags: usb 4, timer a 5, timer b 6; bit 7 reads zero
// - a flag already set at halt entry loses its wake ability
// - wake with source disabled or stack full resumes at next instruction
module utic_top
    import utic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic phase_two_pulse_i,
    input wire utic_usb_ev_t usb_ev_i,
    input wire logic timer_a_ovf_i,
    input wire logic timer_b_ovf_i,
    input wire utic_core_t core_i,
    output utic_ack_t ack_o,
    output logic wake_o,
    output logic resume_next_o,
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0] enables;
    logic [2:0] pending;
    logic [`UTIC_FIFO_N-1:0] fifo_req;
    logic suspend_bit;
    logic resume_bit;
    logic [2:0] wake_mask;
    logic halted;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx[5:0], 2'b00};
    endfunction : byte_addr

    function automatic logic [2:0] pick(input logic [2:0] req);
        // lowest index wins: usb, timer a, timer b
        if (req[0])
            pick = 3'b001;
        else if (req[1])
            pick = 3'b010;
        else if (req[2])
            pick = 3'b100;
        else
            pick = 3'b000;
    endfunction : pick

    // ------------------------------------------------------------
    // request detection
    // ------------------------------------------------------------
    logic usb_event;
    logic [2:0] src_event;
    logic [2:0] eligible;
    logic [2:0] win;
    logic take;
    assign usb_event = usb_ev_i.fifo_hit_0 | usb_ev_i.fifo_hit_1 | usb_ev_i.fifo_hit_2
                     | usb_ev_i.suspend | usb_ev_i.resume | usb_ev_i.bus_reset;
    assign src_event = {timer_b_ovf_i, timer_a_ovf_i, usb_event};
    // masked by global enable and source enables
    assign eligible = pending & enables[3:1] & {3{enables[`UTIC_BIT_GIE]}};
    assign win = pick(eligible);
    // sampled only on phase-two pulse; stack full gates everything
    assign take = phase_two_pulse_i & (|eligible) & ~core_i.stack_full & ~halted;

    // ------------------------------------------------------------
    // bus write channel
    // ------------------------------------------------------------
    logic wr_go;
    // address and data in either order; runs once both are held and b is free
    assign wr_go = aw_held & w_held & ~bvalid_o;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            awready_o <= 1'b1;
        end
        else if (awvalid_i && awready_o)
        begin
            aw_held <= 1'b1;
            aw_addr <= awaddr_i;
            awready_o <= 1'b0;
        end
        else if (wr_go)
        begin
            aw_held <= 1'b0;
            awready_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            wready_o <= 1'b1;
        end
        else if (wvalid_i && wready_o)
        begin
            w_held <= 1'b1;
            w_data <= wdata_i;
            w_strb <= wstrb_i;
            wready_o <= 1'b0;
        end
        else if (wr_go)
        begin
            w_held <= 1'b0;
            wready_o <= 1'b1;
        end
    end

    logic wr_intc;
    logic wr_usbreq;
    logic wr_usbsc;
    logic wr_ok;
    assign wr_intc = wr_go && aw_addr == byte_addr(`UTIC_IDX_INTC) && w_strb[0];
    assign wr_usbreq = wr_go && aw_addr == byte_addr(`UTIC_IDX_USBREQ) && w_strb[0];
    assign wr_usbsc = wr_go && aw_addr == byte_addr(`UTIC_IDX_USBSC) && w_strb[0];
    assign wr_ok = aw_addr == byte_addr(`UTIC_IDX_INTC) || aw_addr == byte_addr(`UTIC_IDX_USBREQ)
                 || aw_addr == byte_addr(`UTIC_IDX_USBSC);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            bvalid_o <= 1'b0;
            bresp_o <= `UTIC_RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_o <= 1'b1;
            bresp_o <= wr_ok ? `UTIC_RESP_OKAY : `UTIC_RESP_SLVERR;
        end
        else if (bready_i)
            bvalid_o <= 1'b0;
    end

    // ------------------------------------------------------------
    // enables and pending flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            enables <= 4'(`UTIC_INTC_RESET);
        else if (take)
            enables[`UTIC_BIT_GIE] <= 1'b0;
        else if (core_i.irq_exit)
            enables[`UTIC_BIT_GIE] <= 1'b1;
        else if (wr_intc)
            enables <= w_data[`UTIC_BIT_BIE:`UTIC_BIT_GIE];
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pending <= 3'(`UTIC_INTC_RESET >> `UTIC_BIT_UPEND);
        else
        begin
            // a new event beats both software clear and acknowledge
            pending <= ((wr_intc ? w_data[`UTIC_BIT_BPEND:`UTIC_BIT_UPEND] : pending)
                        & ~(take ? win : 3'h0)) | src_event;
        end
    end

    // ------------------------------------------------------------
    // usb request and status bits
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            fifo_req <= 3'h0;
        else
            fifo_req <= (wr_usbreq ? (fifo_req & w_data[`UTIC_FIFO_N-1:0]) : fifo_req)
                        | {usb_ev_i.fifo_hit_2, usb_ev_i.fifo_hit_1, usb_ev_i.fifo_hit_0};
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            suspend_bit <= 1'b0;
            resume_bit <= 1'b0;
        end
        else
        begin
            suspend_bit <= (wr_usbsc ? (suspend_bit & w_data[`UTIC_BIT_SUSP]) : suspend_bit)
                           | usb_ev_i.suspend;
            resume_bit <= (wr_usbsc ? (resume_bit & w_data[`UTIC_BIT_RESM]) : resume_bit)
                          | usb_ev_i.resume;
        end
    end

    // ------------------------------------------------------------
    // acknowledge to the core
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            ack_o <= '0;
        else
        begin
            ack_o.take <= take;
            ack_o.push_pc <= take;
            // vector holds between takes so the core may read it late
            if (take)
            begin
                if (win[0])
                    ack_o.vector <= `UTIC_VEC_USB;
                else if (win[1])
                    ack_o.vector <= `UTIC_VEC_TA;
                else
                    ack_o.vector <= `UTIC_VEC_TB;
            end
        end
    end

    // ------------------------------------------------------------
    // halt and wake-up
    // ------------------------------------------------------------
    logic wake_now;
    assign wake_now = halted & |(src_event & wake_mask);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            halted <= 1'b0;
            wake_mask <= 3'h0;
            wake_o <= 1'b0;
            resume_next_o <= 1'b0;
        end
        else
        begin
            wake_o <= wake_now;
            // disabled source or full stack: carry on after halt, no vector
            resume_next_o <= wake_now & ((~|(src_event & wake_mask & enables[3:1]))
                             | ~enables[`UTIC_BIT_GIE] | core_i.stack_full);
            if (core_i.halt_enter && !halted)
            begin
                halted <= 1'b1;
                wake_mask <= ~pending;
            end
            else if (wake_now)
                halted <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // bus read channel
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            arready_o <= 1'b1;
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
            rresp_o <= `UTIC_RESP_OKAY;
        end
        else if (arvalid_i && arready_o)
        begin
            arready_o <= 1'b0;
            rvalid_o <= 1'b1;
            rresp_o <= `UTIC_RESP_OKAY;
            if (araddr_i == byte_addr(`UTIC_IDX_INTC))
                rdata_o <= {24'h0, 1'b0, pending, enables};
            else if (araddr_i == byte_addr(`UTIC_IDX_USBREQ))
                rdata_o <= {29'h0, fifo_req};
            else if (araddr_i == byte_addr(`UTIC_IDX_USBSC))
                rdata_o <= {28'h0, resume_bit, 2'b00, suspend_bit};
            // own status index folds onto byte address 00 of the 8-bit bus
            else if (araddr_i == byte_addr(`UTIC_IDX_CORE))
                rdata_o <= {30'h0, resume_next_o, halted};
            else
            begin
                rdata_o <= 32'h0000_0000;
                rresp_o <= `UTIC_RESP_SLVERR;
            end
        end
        else if (rvalid_o && rready_i)
        begin
            rvalid_o <= 1'b0;
            arready_o <= 1'b1;
        end
    end

endmodule : utic_top

/* File: utic_sva.sv */
// assertion checker for the interrupt controller ports
`timescale 1ns/100ps
module utic_sva
    import utic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic phase_two_pulse_i,
    input wire utic_core_t core_i,
    input wire utic_ack_t ack_o,
    input wire logic wake_o,
    input wire logic resume_next_o,
    input wire logic arvalid_i,
    input wire logic arready_o,
    input wire logic rvalid_o,
    input wire logic rready_i,
    input wire logic [31:0] rdata_o,
    input wire logic bvalid_o,
    input wire logic bready_i,
    input wire logic [1:0] bresp_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // ----
    // acknowledge
    // ----
    property p_take_cause;
        ack_o.take |-> $past(phase_two_pulse_i) && !$past(core_i.stack_full);
    endproperty
    a_take_cause: assert property (p_take_cause) else $error("bad take cause");
    property p_push;
        ack_o.take |-> ack_o.push_pc;
    endproperty
    a_push: assert property (p_push) else $error("take without push");
    property p_vec;
        ack_o.take |-> ack_o.vector inside {12'h004, 12'h008, 12'h00c};
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_block;
        ack_o.take |=> !ack_o.take;
    endproperty
    a_block: assert property (p_block) else $error("take not blocked");
    property p_resume;
        resume_next_o |-> wake_o;
    endproperty
    a_resume: assert property (p_resume) else $error("resume without wake");
    // ----
    // register bus
    // ----
    property p_bhold;
        bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold;
        rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_rlat;
        arvalid_i && arready_o |=> rvalid_o;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
endmodule : utic_sva
bind utic_top utic_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .phase_two_pulse_i(phase_two_pulse_i), .core_i(core_i), .ack_o(ack_o), .wake_o(wake_o),
    .resume_next_o(resume_next_o), .arvalid_i(arvalid_i), .arready_o(arready_o),
    .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o), .bvalid_o(bvalid_o),
    .bready_i(bready_i), .bresp_o(bresp_o));

/* File: utic_core_model.sv */
// core and stack model facing the interrupt controller
`timescale 1ns/100ps
module utic_core_model
    import utic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic full_i,
    input wire logic exit_i,
    input wire logic sub_i,
    input wire logic halt_i,
    output logic phase_two_pulse_o,
    output utic_core_t core_o
);
    logic [1:0] phase;
    // one pulse in four cycles, like an instruction cycle
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end
    assign phase_two_pulse_o = (phase == 2'h3);
    // no calls in service, so the stack fills only on command
    assign core_o = '{irq_exit: exit_i, sub_exit: sub_i, halt_enter: halt_i, stack_full: full_i};
endmodule : utic_core_model

/* File: tb_top.sv */
// self-checking testbench of the interrupt controller
`timescale 1ns/100ps
module tb_top;
    import utic_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic phase_two_pulse_i;
    utic_usb_ev_t usb_ev_i = '0;
    logic timer_a_ovf_i = 1'b0;
    logic timer_b_ovf_i = 1'b0;
    logic full = 1'b0;
    logic ex = 1'b0;
    logic sub = 1'b0;
    logic halt = 1'b0;
    utic_core_t core_i;
    utic_ack_t ack_o;
    logic wake_o, resume_next_o, awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
    logic [7:0] awaddr_i = 8'h00;
    logic [7:0] araddr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic [3:0] wstrb_i = 4'hf;
    logic [31:0] rdata_o;
    logic [1:0] bresp_o, rresp_o;
    logic awvalid_i = 1'b0;
    logic wvalid_i = 1'b0;
    logic bready_i = 1'b0;
    logic arvalid_i = 1'b0;
    logic rready_i = 1'b0;
    int fail_count = 0;
    int checks_done = 0;
    int seed = 32'hefdf;
    int i;
    logic [31:0] d;
    logic [1:0] rs;
    logic [1:0] bs;
    logic [11:0] v;
    logic hit;
    logic [11:0] vecs [2] = '{12'h008, 12'h00c};

    always #2.5 clk_i = ~clk_i;

    utic_core_model u_core (.clk_i, .rst_b_i, .full_i(full), .exit_i(ex), .sub_i(sub),
        .halt_i(halt), .phase_two_pulse_o(phase_two_pulse_i), .core_o(core_i));
    utic_top uut (.clk_i, .rst_b_i, .phase_two_pulse_i, .usb_ev_i, .timer_a_ovf_i,
        .timer_b_ovf_i, .core_i, .ack_o, .wake_o, .resume_next_o, .awaddr_i, .awvalid_i,
        .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o,
        .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i);

    // ----
    // tasks
    // ----
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic limit(input logic ok);
        if (ok !== 1'b1)
        begin
            fail_count++;
            end_of_test();
        end
    endtask : limit
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        int k;
        @(posedge clk_i);
        awaddr_i <= a;
        wdata_i <= {24'h0, x};
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        bready_i <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_i);
            if (awready_o) awvalid_i <= 1'b0;
            if (wready_o) wvalid_i <= 1'b0;
            if (bvalid_o) bready_i <= 1'b0;
            bs = bresp_o;
            k++;
        end
        while (!bvalid_o && k < 40);
        limit(bvalid_o);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge clk_i);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        rready_i <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_i);
            if (arready_o) arvalid_i <= 1'b0;
            d = rdata_o;
            rs = rresp_o;
            k++;
        end
        while (!rvalid_o && k < 40);
        rready_i <= 1'b0;
        limit(rvalid_o);
    endtask : rd
    task automatic ev(input utic_usb_ev_t u, input logic a, input logic b);
        @(posedge clk_i);
        usb_ev_i <= u;
        timer_a_ovf_i <= a;
        timer_b_ovf_i <= b;
        @(posedge clk_i);
        usb_ev_i <= '0;
        timer_a_ovf_i <= 1'b0;
        timer_b_ovf_i <= 1'b0;
    endtask : ev
    // a missing take is a legal outcome here, so no timeout
    task automatic wait_take;
        hit = 1'b0;
        v = 12'h0;
        for (int k = 0; k < 40 && !hit; k++)
        begin
            @(posedge clk_i);
            hit = (ack_o.take === 1'b1) || (wake_o === 1'b1);
            v = (ack_o.take === 1'b1) ? ack_o.vector : {10'h0, wake_o, resume_next_o};
        end
    endtask : wait_take

    // ----
    // scenarios
    // ----
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(8'h2c);
        chk(d, 32'h0);
        rd(8'h10);
        chk({d[29:0], rs}, {30'h0, 2'b10});
        wr(8'h10, 8'h55);
        chk(bs, 2'b10);
        wr(8'h2c, 8'hfe);
        chk(bs, 2'b00);
        rd(8'h2c);
        chk(d, 32'h7e);
        // write with lane 0 off must leave the register alone
        wstrb_i <= 4'h0;
        wr(8'h2c, 8'h00);
        wstrb_i <= 4'hf;
        rd(8'h2c);
        chk(d, 32'h7e);
        for (i = 0; i < 8; i++)
        begin
            wr(8'h2c, 8'h7e & 8'($random(seed)));
            rd(8'h2c);
            chk(d, {24'h0, 8'h7e & wdata_i[7:0]});
        end
        $display("register test done");
        wr(8'h2c, 8'h0f);
        ev(6'b100000, 1'b1, 1'b1);
        wait_take();
        chk({hit, v}, {1'b1, 12'h004});
        rd(8'h2c);
        chk(d, 32'h6e);
        @(posedge clk_i) sub <= 1'b1;
        @(posedge clk_i) sub <= 1'b0;
        wait_take();
        chk(hit, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            @(posedge clk_i) ex <= 1'b1;
            @(posedge clk_i) ex <= 1'b0;
            wait_take();
            chk({hit, v}, {1'b1, vecs[i]});
        end
        $display("priority test done");
        wr(8'h2c, 8'h0e);
        ev(6'h0, 1'b1, 1'b0);
        wait_take();
        chk(hit, 1'b0);
        rd(8'h2c);
        chk(d, 32'h2e);
        full <= 1'b1;
        wr(8'h2c, 8'h25);
        wait_take();
        chk(hit, 1'b0);
        full <= 1'b0;
        wait_take();
        chk({hit, v}, {1'b1, 12'h008});
        $display("mask test done");
        ev(6'b000100, 1'b0, 1'b0);
        rd(8'h80);
        chk(d, 32'h01);
        ev(6'b000010, 1'b0, 1'b0);
        rd(8'h80);
        chk(d, 32'h09);
        ev(6'b010000, 1'b0, 1'b0);
        rd(8'h84);
        chk(d, 32'h03);
        wr(8'h84, 8'h05);
        rd(8'h84);
        chk(d, 32'h01);
        wr(8'h80, 8'h08);
        rd(8'h80);
        chk(d, 32'h08);
        rd(8'h2c);
        chk(d, 32'h14);
        wr(8'h2c, 8'h00);
        @(posedge clk_i) halt <= 1'b1;
        @(posedge clk_i) halt <= 1'b0;
        rd(8'h00);
        chk(d, 32'h01);
        ev(6'h0, 1'b1, 1'b0);
        wait_take();
        chk({hit, v}, {1'b1, 12'h003});
        // timer a still pending at halt entry, so only usb or timer b may wake
        wr(8'h2c, 8'h29);
        @(posedge clk_i) halt <= 1'b1;
        @(posedge clk_i) halt <= 1'b0;
        ev(6'h0, 1'b1, 1'b0);
        wait_take();
        chk(hit, 1'b0);
        ev(6'h0, 1'b0, 1'b1);
        wait_take();
        chk({hit, v}, {1'b1, 12'h002});
        wait_take();
        chk({hit, v}, {1'b1, 12'h00c});
        $display("status and wake test done");
        end_of_test();
    end
endmodule : tb_top
